// ==== rtl/msc_pkg.sv ====
// Package of register map, field layout, reset values and timing for the microstep sequencer config.
package msc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    // Register indices; the byte address is four times the index.
    localparam logic [6:0] IDX_SEQ_CONFIG = 7'h54;
    localparam logic [6:0] IDX_CURRENT_CTRL = 7'h55;
    localparam logic [6:0] IDX_STALL_LEVEL = 7'h56;
    localparam logic [6:0] IDX_DRV_STATUS = 7'h57;
    localparam logic [6:0] IDX_CHOP_DIV = 7'h59;
    localparam logic [6:0] IDX_STALL_THRS = 7'h5A;
    localparam logic [6:0] IDX_MOTOR_CFG = 7'h5B;
    localparam logic [6:0] IDX_STBY_DELAY = 7'h5C;
    localparam logic [6:0] IDX_IDENTITY = 7'h60;
    localparam logic [6:0] IDX_INT_MASK = 7'h61;
    localparam logic [6:0] IDX_INT_FLAG = 7'h62;
    // Sequencer configuration fields.
    localparam int SEQ_LEN_LSB = 0;
    localparam int SEQ_STOP_BIT = 8;
    localparam logic [3:0] SEQ_LEN_RESET = 4'h0;
    localparam logic [3:0] SEQ_LEN_MAX = 4'hB;
    localparam int TABLE_BITS = 13;
    // Current control fields.
    localparam int CUR_RUN_LSB = 0;
    localparam int CUR_RUN_MIX_BIT = 7;
    localparam int CUR_SB_LSB = 8;
    localparam int CUR_SB_MIX_BIT = 15;
    localparam logic [23:0] CUR_CTRL_RESET = 24'h000090;
    localparam logic [4:0] SCALE_FULL = 5'h10;
    // Driver status bits.
    localparam int DRV_ERR_BIT = 0;
    localparam int DRV_OTPW_BIT = 1;
    localparam int DRV_STALL_BIT = 2;
    // Motor configuration fields.
    localparam int MCFG_STEPPER_BIT = 0;
    localparam int MCFG_STOP_STALL_BIT = 1;
    localparam logic [1:0] MCFG_RESET = 2'h1;
    localparam logic [2:0] STALL_THRS_RESET = 3'h0;
    // Chopper divider.
    localparam logic [11:0] CHOP_DIV_MIN = 12'h060;
    localparam logic [11:0] CHOP_DIV_RESET = 12'h280;
    // Interrupt flag bits.
    localparam int INT_STOP_BIT = 3;
    localparam int INT_DRV_BIT = 4;
    localparam logic [7:0] INT_IMPL_MASK = 8'h18;
    // Standby delay: time in milliseconds and the derived cycle count.
    localparam int CLK_MHZ = 100;
    localparam int STBY_DELAY_MS = 10;
    localparam logic [23:0] STBY_DELAY_CYCLES = 24'(STBY_DELAY_MS * CLK_MHZ * 1000);
endpackage : msc_pkg

// ==== rtl/msc_scale_if.sv ====
// Interface carrying table entries and the active scale into the current scaler.
`timescale 1ns/1ps
`default_nettype none
interface msc_scale_if;
    logic signed [11:0] entry_a;
    logic signed [11:0] entry_b;
    logic [4:0] scale;
    logic scaling_en;
    logic signed [11:0] out_a;
    logic signed [11:0] out_b;
    logic drv_disable;
    modport ctrl (output entry_a, output entry_b, output scale, output scaling_en,
                  input out_a, input out_b, input drv_disable);
    modport scaler (input entry_a, input entry_b, input scale, input scaling_en,
                    output out_a, output out_b, output drv_disable);
endinterface : msc_scale_if
`default_nettype wire

// ==== rtl/msc_current_scaler.sv ====
// Combinational current scaler applying scale/16 to both coil entries.
`timescale 1ns/1ps
`default_nettype none
module msc_current_scaler (
    msc_scale_if.scaler sif
);
    // Scales above full are clamped so the product can never exceed the table range.
    function automatic logic signed [11:0] msc_scale_entry(input logic signed [11:0] e,
                                                           input logic [4:0] s);
        logic [4:0] sc;
        logic signed [17:0] prod;
        sc = (s > msc_pkg::SCALE_FULL) ? msc_pkg::SCALE_FULL : s;
        prod = e * $signed({1'b0, sc});
        return prod[15:4];
    endfunction : msc_scale_entry

    always_comb begin
        if (sif.scaling_en) begin
            sif.out_a = msc_scale_entry(sif.entry_a, sif.scale);
            sif.out_b = msc_scale_entry(sif.entry_b, sif.scale);
            sif.drv_disable = (sif.scale == 5'h00);
        end else begin
            sif.out_a = sif.entry_a;
            sif.out_b = sif.entry_b;
            sif.drv_disable = 1'b0;
        end
    end
endmodule : msc_current_scaler
`default_nettype wire

// ==== rtl/msc_seq_config.sv ====
// Top of the microstep sequencer configuration bank with Avalon-MM slave and driver control.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module msc_seq_config #(
    parameter logic [23:0] ID_CODE = 24'hA5C3E1, // Arbitrary identity value.
    parameter logic [23:0] STBY_DELAY_CYCLES = msc_pkg::STBY_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [msc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [msc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [msc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic signed [11:0] table_entry_a,
    input wire logic signed [11:0] table_entry_b,
    input wire logic drv_error_pin,
    input wire logic drv_otpw_pin,
    input wire logic drv_stall_pin,
    input wire logic [2:0] stall_level_pin,
    output logic [msc_pkg::TABLE_BITS-1:0] table_index,
    output logic [11:0] microstep_res,
    output logic signed [11:0] coil_a,
    output logic signed [11:0] coil_b,
    output logic drv_enable,
    output logic mixed_decay_en,
    output logic standby_active,
    output logic [2:0] stall_threshold,
    output logic motor_stopped,
    output logic chop_clk,
    output logic irq
);
    generate
        if (STBY_DELAY_CYCLES == 24'h000000) begin : g_bad_delay
            $error("Standby delay must be at least one cycle.");
        end
    endgenerate

    typedef enum logic [0:0] {
        MSC_BUS_IDLE = 1'b0,
        MSC_BUS_ACK = 1'b1
    } msc_bus_e;

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] msc_merge(input logic [31:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : msc_merge

    logic [8:0] seq_config_reg;
    logic [23:0] current_ctrl_reg;
    logic [11:0] chop_div_reg;
    logic [2:0] stall_thrs_reg;
    logic [1:0] motor_cfg_reg;
    logic [23:0] stby_delay_reg;
    logic [7:0] int_mask_reg;
    logic [7:0] int_flag_reg;
    logic [7:0] int_flag_next;
    logic stall_stop_reg;
    msc_bus_e bus_state_reg;
    logic [31:0] readdata_reg;
    logic [31:0] rd_value;
    logic [6:0] reg_idx;
    logic wr_fire;

    logic [2:0] drv_meta_reg;
    logic [2:0] drv_sync_reg;
    logic [2:0] drv_prev_reg;
    logic [2:0] lvl_meta_reg;
    logic [2:0] lvl_sync_reg;

    logic [msc_pkg::TABLE_BITS-1:0] phase_reg;
    logic [23:0] idle_cnt_reg;
    logic standby_reg;
    logic [11:0] chop_cnt_reg;
    logic chop_clk_reg;
    logic signed [11:0] coil_a_reg;
    logic signed [11:0] coil_b_reg;
    logic drv_enable_reg;
    logic mixed_decay_reg;
    logic [11:0] ustep_res_reg;
    logic irq_reg;

    logic [3:0] len_code;
    logic seq_stop;
    logic [11:0] chop_wr;

    msc_scale_if sif ();

    msc_current_scaler u_scaler (
        .sif(sif)
    );

    assign reg_idx = avs_address[8:2];
    assign wr_fire = avs_write && (bus_state_reg == MSC_BUS_ACK);
    assign len_code = (seq_config_reg[3:0] > msc_pkg::SEQ_LEN_MAX) ?
                      msc_pkg::SEQ_LEN_MAX : seq_config_reg[3:0];
    assign seq_stop = seq_config_reg[msc_pkg::SEQ_STOP_BIT];
    assign chop_wr = 12'(msc_merge({20'h00000, chop_div_reg}, avs_writedata, avs_byteenable));

    // Bus handshake: one wait cycle, then waitrequest drops for exactly one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= MSC_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                MSC_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= MSC_BUS_ACK;
                    end
                end
                MSC_BUS_ACK: bus_state_reg <= MSC_BUS_IDLE;
                default: bus_state_reg <= MSC_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((bus_state_reg == MSC_BUS_IDLE) && (avs_read || avs_write));
        end
    end

    always_comb begin
        rd_value = 32'h00000000;
        case (reg_idx)
            msc_pkg::IDX_SEQ_CONFIG: rd_value = {23'h000000, seq_config_reg};
            msc_pkg::IDX_STALL_LEVEL: rd_value = {29'h00000000, lvl_sync_reg};
            msc_pkg::IDX_DRV_STATUS: rd_value = {29'h00000000, drv_sync_reg};
            msc_pkg::IDX_MOTOR_CFG: rd_value = {30'h00000000, motor_cfg_reg};
            msc_pkg::IDX_STBY_DELAY: rd_value = {8'h00, stby_delay_reg};
            msc_pkg::IDX_IDENTITY: rd_value = {8'h00, ID_CODE};
            msc_pkg::IDX_INT_MASK: rd_value = {24'h000000, int_mask_reg};
            msc_pkg::IDX_INT_FLAG: rd_value = {24'h000000, int_flag_reg};
            default: rd_value = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_reg <= 32'h00000000;
        end else if ((bus_state_reg == MSC_BUS_IDLE) && avs_read) begin
            readdata_reg <= rd_value;
        end
    end
    assign avs_readdata = readdata_reg;

    // Software-written configuration registers; writes land at the edge waitrequest is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_config_reg <= {5'h00, msc_pkg::SEQ_LEN_RESET};
            current_ctrl_reg <= msc_pkg::CUR_CTRL_RESET;
            stall_thrs_reg <= msc_pkg::STALL_THRS_RESET;
            motor_cfg_reg <= msc_pkg::MCFG_RESET;
            stby_delay_reg <= STBY_DELAY_CYCLES;
            int_mask_reg <= 8'h00;
        end else if (wr_fire) begin
            case (reg_idx)
                msc_pkg::IDX_SEQ_CONFIG: begin
                    seq_config_reg <= 9'(msc_merge({23'h000000, seq_config_reg}, avs_writedata,
                                                   avs_byteenable) & 32'h0000010F);
                end
                msc_pkg::IDX_CURRENT_CTRL: begin
                    current_ctrl_reg <= 24'(msc_merge({8'h00, current_ctrl_reg},
                                                      avs_writedata, avs_byteenable));
                end
                msc_pkg::IDX_STALL_THRS: begin
                    if (avs_byteenable[0]) begin
                        stall_thrs_reg <= avs_writedata[2:0];
                    end
                end
                msc_pkg::IDX_MOTOR_CFG: begin
                    if (avs_byteenable[0]) begin
                        motor_cfg_reg <= avs_writedata[1:0];
                    end
                end
                msc_pkg::IDX_STBY_DELAY: begin
                    stby_delay_reg <= 24'(msc_merge({8'h00, stby_delay_reg}, avs_writedata,
                                                    avs_byteenable));
                end
                msc_pkg::IDX_INT_MASK: begin
                    if (avs_byteenable[0]) begin
                        int_mask_reg <= avs_writedata[7:0] & msc_pkg::INT_IMPL_MASK;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // A too-small divider could overrun the chopper, so it is clamped rather than dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_div_reg <= msc_pkg::CHOP_DIV_RESET;
        end else if (wr_fire && (reg_idx == msc_pkg::IDX_CHOP_DIV) &&
                     (avs_byteenable[1:0] != 2'h0)) begin
            if (chop_wr < msc_pkg::CHOP_DIV_MIN) begin
                chop_div_reg <= msc_pkg::CHOP_DIV_MIN;
            end else begin
                chop_div_reg <= chop_wr;
            end
        end
    end

    // Driver pins come from another chip and pass two flip-flops first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_meta_reg <= 3'h0;
            drv_sync_reg <= 3'h0;
            drv_prev_reg <= 3'h0;
            lvl_meta_reg <= 3'h0;
            lvl_sync_reg <= 3'h0;
        end else begin
            drv_meta_reg <= {drv_stall_pin, drv_otpw_pin, drv_error_pin};
            drv_sync_reg <= drv_meta_reg;
            drv_prev_reg <= drv_sync_reg;
            lvl_meta_reg <= stall_level_pin;
            lvl_sync_reg <= lvl_meta_reg;
        end
    end

    // Sticky interrupt flags; a new event wins over a same-cycle write-one clear.
    always_comb begin
        int_flag_next = int_flag_reg;
        if (wr_fire && (reg_idx == msc_pkg::IDX_INT_FLAG) && avs_byteenable[0]) begin
            int_flag_next = int_flag_reg & ~avs_writedata[7:0];
        end
        if (drv_sync_reg[msc_pkg::DRV_ERR_BIT] && !drv_prev_reg[msc_pkg::DRV_ERR_BIT]) begin
            int_flag_next[msc_pkg::INT_DRV_BIT] = 1'b1;
        end
        if (motor_cfg_reg[msc_pkg::MCFG_STOP_STALL_BIT] &&
                drv_sync_reg[msc_pkg::DRV_STALL_BIT] && !drv_prev_reg[msc_pkg::DRV_STALL_BIT]) begin
            int_flag_next[msc_pkg::INT_STOP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_flag_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            int_flag_reg <= int_flag_next;
            irq_reg <= |(int_flag_next & int_mask_reg);
        end
    end

    // The stall stop holds until the stall has ended and software has cleared the stop flag, or until software disables the feature.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_stop_reg <= 1'b0;
        end else if (motor_cfg_reg[msc_pkg::MCFG_STOP_STALL_BIT] &&
                     drv_sync_reg[msc_pkg::DRV_STALL_BIT]) begin
            stall_stop_reg <= 1'b1;
        end else if (!motor_cfg_reg[msc_pkg::MCFG_STOP_STALL_BIT] ||
                     !int_flag_reg[msc_pkg::INT_STOP_BIT]) begin
            stall_stop_reg <= 1'b0;
        end
    end

    // The phase advances by the table stride so shorter tables skip entries of the full one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 13'h0000;
        end else if (step_pulse && !seq_stop && !stall_stop_reg) begin
            if (step_dir) begin
                phase_reg <= phase_reg + (13'h0001 << len_code);
            end else begin
                phase_reg <= phase_reg - (13'h0001 << len_code);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ustep_res_reg <= 12'h800;
        end else begin
            ustep_res_reg <= 12'h800 >> len_code;
        end
    end

    // Idle time counts from the last step that actually moved the sequencer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_reg <= 24'h000000;
            standby_reg <= 1'b0;
        end else if (step_pulse && !seq_stop && !stall_stop_reg) begin
            idle_cnt_reg <= 24'h000000;
            standby_reg <= 1'b0;
        end else if (idle_cnt_reg >= stby_delay_reg) begin
            standby_reg <= 1'b1;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 24'h000001;
        end
    end

    assign sif.entry_a = table_entry_a;
    assign sif.entry_b = table_entry_b;
    assign sif.scaling_en = motor_cfg_reg[msc_pkg::MCFG_STEPPER_BIT];
    assign sif.scale = standby_reg ? current_ctrl_reg[msc_pkg::CUR_SB_LSB +: 5] :
                       current_ctrl_reg[msc_pkg::CUR_RUN_LSB +: 5];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_a_reg <= 12'sh000;
            coil_b_reg <= 12'sh000;
            drv_enable_reg <= 1'b0;
            mixed_decay_reg <= 1'b0;
        end else begin
            coil_a_reg <= sif.out_a;
            coil_b_reg <= sif.out_b;
            drv_enable_reg <= !sif.drv_disable;
            if (standby_reg) begin
                mixed_decay_reg <= current_ctrl_reg[msc_pkg::CUR_SB_MIX_BIT];
            end else begin
                mixed_decay_reg <= current_ctrl_reg[msc_pkg::CUR_RUN_MIX_BIT];
            end
        end
    end

    // Chopper clock runs at clk divided by the divider, high for the first half period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_cnt_reg <= 12'h000;
            chop_clk_reg <= 1'b0;
        end else if (chop_cnt_reg >= chop_div_reg - 12'h001) begin
            chop_cnt_reg <= 12'h000;
            chop_clk_reg <= 1'b1;
        end else begin
            chop_cnt_reg <= chop_cnt_reg + 12'h001;
            chop_clk_reg <= (chop_cnt_reg + 12'h001) < (chop_div_reg >> 1);
        end
    end

    assign table_index = phase_reg;
    assign microstep_res = ustep_res_reg;
    assign coil_a = coil_a_reg;
    assign coil_b = coil_b_reg;
    assign drv_enable = drv_enable_reg;
    assign mixed_decay_en = mixed_decay_reg;
    assign standby_active = standby_reg;
    assign stall_threshold = stall_thrs_reg;
    assign motor_stopped = stall_stop_reg;
    assign chop_clk = chop_clk_reg;
    assign irq = irq_reg;
endmodule : msc_seq_config
`default_nettype wire

// ==== testbench/msc_seq_config_asserts.sv ====
// Concurrent checks on the ports of the sequencer configuration bank.
`timescale 1ns/1ps
`default_nettype none
module msc_seq_config_asserts #(
    parameter logic [23:0] ID_CODE = 24'h000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [msc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic [msc_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic step_pulse,
    input wire logic drv_stall_pin,
    input wire logic [msc_pkg::TABLE_BITS-1:0] table_index,
    input wire logic [11:0] microstep_res,
    input wire logic standby_active,
    input wire logic motor_stopped,
    input wire logic chop_clk
);
    logic [11:0] hi_cnt;
    // Length of the current high phase of the chopper clock.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= 12'h000;
        end else begin
            hi_cnt <= chop_clk ? hi_cnt + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence rd_ack(logic [6:0] i);
        avs_read && !avs_waitrequest && avs_address[8:2] == i;
    endsequence
    wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ($rose(avs_read) |-> ##[1:2] !avs_waitrequest)
        else $error("read not answered in time");
    id_read_a: assert property (rd_ack(7'h60) |-> avs_readdata == {8'h00, ID_CODE})
        else $error("identity read wrong");
    level_read_a: assert property (rd_ack(7'h56) |-> avs_readdata[31:3] == 29'h0)
        else $error("stall level upper bits set");
    status_read_a: assert property (rd_ack(7'h57) |-> avs_readdata[31:3] == 29'h0)
        else $error("status upper bits set");
    index_cause_a: assert property ($changed(table_index) |-> $past(step_pulse))
        else $error("index moved without a step");
    res_onehot_a: assert property ($onehot(microstep_res))
        else $error("resolution not a power of two");
    stop_freeze_a: assert property (motor_stopped |=> $stable(table_index))
        else $error("index moved while stopped");
    stall_cause_a: assert property ($rose(motor_stopped) |-> $past(drv_stall_pin, 3))
        else $error("stop without stall");
    stby_rise_a: assert property ($rose(standby_active) |-> !$past(step_pulse))
        else $error("standby right after a step");
    chop_high_a: assert property ($fell(chop_clk) |-> hi_cnt >= 12'h030)
        else $error("chopper high phase too short");
endmodule : msc_seq_config_asserts
bind msc_seq_config msc_seq_config_asserts #(.ID_CODE(ID_CODE)) u_chk (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .step_pulse(step_pulse), .drv_stall_pin(drv_stall_pin), .table_index(table_index),
    .microstep_res(microstep_res), .standby_active(standby_active),
    .motor_stopped(motor_stopped), .chop_clk(chop_clk)
);
`default_nettype wire

// ==== testbench/msc_drv_model.sv ====
// Behavioural model of the external power stage that reports status pins.
`timescale 1ns/1ps
`default_nettype none
module msc_drv_model (
    input wire logic drv_enable,
    input wire logic [2:0] fault_cmd,
    input wire logic [2:0] level_cmd,
    output logic drv_error_pin,
    output logic drv_otpw_pin,
    output logic drv_stall_pin,
    output logic [2:0] stall_level_pin
);
    assign drv_error_pin = fault_cmd[0];
    assign drv_otpw_pin = fault_cmd[1];
    // A disabled stage has no back-EMF to sense, so it cannot report a stall.
    assign drv_stall_pin = fault_cmd[2] && drv_enable;
    assign stall_level_pin = level_cmd;
endmodule : msc_drv_model
`default_nettype wire

// ==== testbench/microstep_sequencer_config_tb.sv ====
// Self-checking testbench for the sequencer configuration bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module microstep_sequencer_config_tb;
    localparam logic [23:0] ID = 24'h3C5A96; // Arbitrary identity value.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] a = 9'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic stp = 1'b0;
    logic dir = 1'b1;
    logic [31:0] wd = 32'h0;
    logic [2:0] cmd = 3'h0;
    logic [2:0] lvl = 3'h0;
    logic [31:0] rq, q;
    logic wt, pe, po, ps, den, mix, sby, mst, chp, irq;
    logic [2:0] pl, thr;
    logic [12:0] idx, p;
    logic [11:0] res, ca, cb;
    int num_errors = 0;
    int checked = 0;
    time t0;
    msc_drv_model u_drv (.drv_enable(den), .fault_cmd(cmd), .level_cmd(lvl),
        .drv_error_pin(pe), .drv_otpw_pin(po), .drv_stall_pin(ps), .stall_level_pin(pl));
    msc_seq_config #(.ID_CODE(ID), .STBY_DELAY_CYCLES(24'h000800)) u_dut (
        .clk(clk), .rst_n(rst_n), .avs_address(a), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rq),
        .avs_waitrequest(wt), .step_pulse(stp), .step_dir(dir),
        .table_entry_a(12'h064), .table_entry_b(12'hF9C), .drv_error_pin(pe),
        .drv_otpw_pin(po), .drv_stall_pin(ps), .stall_level_pin(pl), .table_index(idx),
        .microstep_res(res), .coil_a(ca), .coil_b(cb), .drv_enable(den),
        .mixed_decay_en(mix), .standby_active(sby), .stall_threshold(thr),
        .motor_stopped(mst), .chop_clk(chp), .irq(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    // Waits for the answer however long it takes; only the watchdog ends a hung access.
    task automatic bus(input logic w, input logic [6:0] i, input logic [31:0] d);
        a <= {i, 2'b00};
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wt !== 1'b0);
        q = rq;
        rd <= 1'b0;
        wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : bus
    task automatic step();
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : step
    // The first period after a divider change may be partial, so skip it.
    task automatic per(input int e);
        @(posedge chp);
        @(posedge chp);
        t0 = $time;
        @(posedge chp);
        `CHK("chop period", e, int'(($time - t0) / 10))
    endtask : per
    task automatic final_report();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("mixed run", 1'b1, mix)
        bus(1'b1, 7'h60, 32'h0);
        bus(1'b0, 7'h60, 32'h0);
        `CHK("identity", {8'h00, ID}, q)
        for (int k = 0; k < 12; k++) begin
            bus(1'b1, 7'h54, k);
            p = idx;
            step();
            `CHK("index", 13'(p + (13'h1 << k)), idx)
            `CHK("resolution", 12'(12'h800 >> k), res)
        end
        dir <= 1'b0;
        p = idx;
        step();
        `CHK("index down", 13'(p - 13'h800), idx)
        bus(1'b1, 7'h54, 32'h100);
        p = idx;
        step();
        `CHK("seq stop", p, idx)
        bus(1'b0, 7'h54, 32'h0);
        `CHK("seq cfg", 32'h100, q)
        bus(1'b1, 7'h54, 32'h0);
        bus(1'b1, 7'h55, 32'h88);
        `CHK("coil a", 12'h032, ca)
        `CHK("coil b", 12'hFCE, cb)
        bus(1'b0, 7'h55, 32'h0);
        `CHK("wo read", 32'h0, q)
        bus(1'b1, 7'h5B, 32'h0);
        `CHK("unscaled", 12'h064, ca)
        bus(1'b1, 7'h5B, 32'h1);
        bus(1'b1, 7'h55, 32'h0);
        `CHK("drv off", 1'b0, den)
        `CHK("mixed off", 1'b0, mix)
        bus(1'b1, 7'h55, 32'h8410);
        step();
        bus(1'b1, 7'h5C, 32'h14);
        repeat (40) @(posedge clk);
        `CHK("standby", 1'b1, sby)
        `CHK("sb coil", 12'h019, ca)
        `CHK("sb mixed", 1'b1, mix)
        bus(1'b1, 7'h5A, 32'h5);
        `CHK("threshold", 3'h5, thr)
        bus(1'b1, 7'h61, 32'h10);
        bus(1'b1, 7'h5B, 32'h3);
        lvl <= 3'h5;
        cmd <= 3'h7;
        repeat (8) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        bus(1'b0, 7'h57, 32'h0);
        `CHK("status", 32'h7, q)
        bus(1'b0, 7'h56, 32'h0);
        `CHK("level", 32'h5, q)
        bus(1'b0, 7'h62, 32'h0);
        `CHK("flag", 5'h18, q[4:0])
        `CHK("stopped", 1'b1, mst)
        p = idx;
        step();
        `CHK("stall hold", p, idx)
        cmd <= 3'h0;
        repeat (6) @(posedge clk);
        `CHK("stop held", 1'b1, mst)
        bus(1'b1, 7'h62, 32'h18);
        `CHK("irq clr", 1'b0, irq)
        `CHK("released", 1'b0, mst)
        bus(1'b1, 7'h61, 32'h0);
        cmd <= 3'h1;
        repeat (8) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b0, 7'h70, 32'h0);
        `CHK("unmapped", 32'h0, q)
        per(640);
        bus(1'b1, 7'h59, 32'h32);
        per(96);
        bus(1'b1, 7'h59, 32'hC8);
        per(200);
        final_report();
    end
endmodule : microstep_sequencer_config_tb
`undef CHK
`default_nettype wire
